// ===== verilog/serial_eeprom.v
`timescale 1ns/1ps
`include "eeprom_ctrl_regs.vh"
module serial_eeprom #(
    parameter WORD16 = 1,
    parameter T_WRITE_CYC = 1500000,
    parameter T_ERASE_WHOLE_ARRAY_CYC = 1500000,
    parameter T_WRITE_WHOLE_ARRAY_CYC = 3750000
) (
    // clock, reset, enable
    input wire clk,
    input wire rst_n,
    input wire ce,
    // serial pins
    input wire select,
    input wire serial_clk,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_oe,
    // status
    output reg standby,
    output reg busy
);
    localparam DW = WORD16 ? 16 : 8;
    localparam AW = WORD16 ? 7 : 8;
    localparam HDR = 2 + AW; // opcode plus address bits
    // one-hot states
    localparam S_IDLE = 5'h01;
    localparam S_HDR = 5'h02;
    localparam S_DATA = 5'h04;
    localparam S_READ = 5'h08;
    localparam S_DONE = 5'h10;
    localparam P_IDLE = 3'h1;
    localparam P_ARM = 3'h2;
    localparam P_RUN = 3'h4;

    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [2:0] cs_sync_reg, ck_sync_reg, di_sync_reg;
    reg [4:0] st_reg;
    reg [2:0] pst_reg;
    reg [4:0] cnt_reg;
    reg [HDR-1:0] hdr_reg;
    reg [DW-1:0] shift_reg;
    reg [DW-1:0] rd_reg;
    reg unlocked_reg;
    reg [1:0] pop_reg; // 0 none,1 erase/write,2 erase_whole_array,3 write_whole_array
    reg [AW-1:0] paddr_reg;
    reg [DW-1:0] pdata_reg;
    reg [21:0] ptime_reg;
    reg [AW:0] wipe_reg;
    reg wiping_reg;
    reg pwrite_reg;
    reg [AW-1:0] raddr_reg;

    // pins cross domains through two flops; third stage only for edge detect
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_reg <= 3'h0;
            ck_sync_reg <= 3'h0;
            di_sync_reg <= 3'h0;
        end else if (ce) begin
            cs_sync_reg <= {cs_sync_reg[1:0], select};
            ck_sync_reg <= {ck_sync_reg[1:0], serial_clk};
            di_sync_reg <= {di_sync_reg[1:0], serial_in};
        end
    end
    wire cs = cs_sync_reg[1];
    wire di = di_sync_reg[1];
    wire ck_rise = ck_sync_reg[1] && !ck_sync_reg[2];
    wire cs_fall = !cs_sync_reg[1] && cs_sync_reg[2];
    wire [1:0] op = hdr_reg[HDR-1:HDR-2];
    wire [1:0] ext = hdr_reg[AW-1:AW-2];
    wire [AW-1:0] addr = hdr_reg[AW-1:0];

    // read data drains through a small fifo, one word per read
    wire fifo_in_valid = (st_reg == S_HDR) && ck_rise && cs && (cnt_reg == HDR[4:0] - 1'b1)
                         && ({hdr_reg[HDR-2:0], di} >> AW) == {1'b1, 1'b0};
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [DW-1:0] fifo_out_data;
    // drained while deselected, so an aborted read leaves no stale word behind
    wire fifo_pop = fifo_out_valid && (!cs || ((st_reg == S_READ) && cnt_reg == 5'h0 && ck_rise));
    stream_fifo #(.WIDTH(DW), .DEPTH(4), .AW(2)) read_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(mem[{hdr_reg[AW-2:0], di}]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // instruction sequencer; held idle while deselected
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= S_IDLE;
            cnt_reg <= 5'h0;
            hdr_reg <= {HDR{1'b0}};
            shift_reg <= {DW{1'b0}};
            unlocked_reg <= 1'b0;
            raddr_reg <= {AW{1'b0}};
        end else if (ce) begin
            if (!cs) begin
                st_reg <= S_IDLE;
                cnt_reg <= 5'h0;
            end else if (ck_rise) begin
                case (st_reg)
                    S_IDLE: if (di && pst_reg == P_IDLE) begin
                        st_reg <= S_HDR;
                        cnt_reg <= 5'h0;
                    end
                    S_HDR: begin
                        hdr_reg <= {hdr_reg[HDR-2:0], di};
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg == HDR[4:0] - 1'b1) begin
                            cnt_reg <= 5'h0;
                            case ({hdr_reg[HDR-2:0], di} >> AW)
                                {1'b0, 1'b0}: begin
                                    st_reg <= S_DONE;
                                    if (hdr_reg[AW-2:AW-3] == `EXT_UNLOCK)
                                        unlocked_reg <= 1'b1;
                                    else if (hdr_reg[AW-2:AW-3] == `EXT_LOCK)
                                        unlocked_reg <= 1'b0;
                                    else if (hdr_reg[AW-2:AW-3] == `EXT_WRITE_WHOLE_ARRAY)
                                        st_reg <= S_DATA;
                                end
                                {1'b0, 1'b1}: st_reg <= S_DATA;
                                {1'b1, 1'b0}: begin
                                    st_reg <= S_READ; // dummy zero then data
                                    raddr_reg <= {hdr_reg[AW-2:0], di};
                                end
                                default: st_reg <= S_DONE;
                            endcase
                        end
                    end
                    S_DATA: begin
                        shift_reg <= {shift_reg[DW-2:0], di};
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg == DW[4:0] - 1'b1)
                            st_reg <= S_DONE;
                    end
                    S_READ: begin
                        cnt_reg <= (cnt_reg == DW[4:0]) ? 5'h1 : cnt_reg + 1'b1;
                        if (cnt_reg == DW[4:0] - 1'b1)
                            raddr_reg <= raddr_reg + 1'b1; // sequential read, next word ready in time
                    end
                    S_DONE: st_reg <= S_DONE;
                    default: st_reg <= S_IDLE;
                endcase
            end
        end
    end

    // program engine: armed at end of instruction, starts at select fall
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pst_reg <= P_IDLE;
            pop_reg <= 2'h0;
            paddr_reg <= {AW{1'b0}};
            pdata_reg <= {DW{1'b0}};
            ptime_reg <= 22'h0;
            wipe_reg <= {(AW+1){1'b0}};
            wiping_reg <= 1'b0;
            pwrite_reg <= 1'b0;
        end else if (ce) begin
            case (pst_reg)
                P_IDLE: if (st_reg == S_DONE && cs && unlocked_reg) begin
                    pst_reg <= P_ARM;
                    paddr_reg <= addr;
                    pdata_reg <= shift_reg;
                    pop_reg <= (op == `OP_EXT) ? ((ext == `EXT_ERASE_WHOLE_ARRAY) ? 2'h2 :
                               (ext == `EXT_WRITE_WHOLE_ARRAY) ? 2'h3 : 2'h0) : 2'h1;
                    pwrite_reg <= (op == `OP_WRITE);
                    if (op == `OP_READ || (op == `OP_EXT && (ext == `EXT_LOCK || ext == `EXT_UNLOCK)))
                        pst_reg <= P_IDLE;
                end
                P_ARM: if (!cs) begin
                    pst_reg <= P_RUN;
                    ptime_reg <= (pop_reg == 2'h3) ? T_WRITE_WHOLE_ARRAY_CYC[21:0] :
                                 (pop_reg == 2'h2) ? T_ERASE_WHOLE_ARRAY_CYC[21:0] : T_WRITE_CYC[21:0];
                    wipe_reg <= {(AW+1){1'b0}};
                    wiping_reg <= (pop_reg != 2'h1);
                    if (pop_reg == 2'h1)
                        mem[paddr_reg] <= {DW{1'b1}}; // erase before program
                end
                P_RUN: begin
                    // runs to the end whatever select does
                    ptime_reg <= ptime_reg - 1'b1;
                    if (wiping_reg) begin
                        mem[wipe_reg[AW-1:0]] <= (pop_reg == 2'h3) ? pdata_reg : {DW{1'b1}};
                        wipe_reg <= wipe_reg + 1'b1;
                        if (wipe_reg[AW-1:0] == {AW{1'b1}})
                            wiping_reg <= 1'b0;
                    end else if (pwrite_reg) begin
                        mem[paddr_reg] <= pdata_reg;
                        pwrite_reg <= 1'b0;
                    end
                    if (ptime_reg == 22'h1)
                        pst_reg <= P_IDLE;
                end
                default: pst_reg <= P_IDLE;
            endcase
        end
    end

    // pins and status outputs, all registered
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
            standby <= 1'b1;
            busy <= 1'b0;
            rd_reg <= {DW{1'b0}};
        end else if (ce) begin
            busy <= (pst_reg == P_RUN);
            // armed but not yet running also keeps standby low, though busy is raised only in run, so no standby blip
            standby <= !cs && pst_reg == P_IDLE;
            if (cs_fall || !cs) begin
                serial_out_oe <= 1'b0;
            end else if (pst_reg == P_RUN) begin
                serial_out_oe <= 1'b1;
                serial_out <= 1'b0;
            end else if (fifo_in_valid) begin
                serial_out_oe <= 1'b1;
                serial_out <= 1'b0; // dummy zero on the last address bit
            end else if (st_reg == S_READ && ck_rise) begin
                serial_out_oe <= 1'b1;
                if (cnt_reg == 5'h0) begin
                    rd_reg <= fifo_out_data;
                    serial_out <= fifo_out_data[DW-1];
                end else if (cnt_reg == DW[4:0]) begin
                    rd_reg <= mem[raddr_reg];
                    serial_out <= mem[raddr_reg][DW-1];
                end else begin
                    serial_out <= rd_reg[DW-1-cnt_reg];
                end
            end else if (st_reg != S_READ && pst_reg == P_IDLE && pop_reg != 2'h0 && serial_out_oe) begin
                serial_out <= 1'b1;
            end
        end
    end
endmodule

// ===== verilog/eeprom_ctrl_regs.vh
`ifndef EEPROM_CTRL_REGS_VH
`define EEPROM_CTRL_REGS_VH
`define CLK_PERIOD_PS 4000
`define CS_LOW_MIN_NS 250
`define T_WRITE_MS 6
`define T_ERASE_WHOLE_ARRAY_MS 6
`define T_WRITE_WHOLE_ARRAY_MS 15
`define OP_EXT 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define EXT_LOCK 2'h0
`define EXT_WRITE_WHOLE_ARRAY 2'h1
`define EXT_ERASE_WHOLE_ARRAY 2'h2
`define EXT_UNLOCK 2'h3
`endif

// ===== verilog/stream_fifo.v
`timescale 1ns/1ps
module stream_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // write side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // read side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];

    // pointers wrap at depth; depth need not be a power of two
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

    // storage, no reset needed
    always @(posedge clk) begin
        if (ce && push)
            mem[wr_ptr_reg] <= in_data;
    end
endmodule

// ===== tb/serial_eeprom_checker.sv
`timescale 1ns/1ps
module serial_eeprom_checker #(
    parameter T_WRITE_CYC = 300,
    parameter T_ERASE_WHOLE_ARRAY_CYC = 300,
    parameter T_WRITE_WHOLE_ARRAY_CYC = 600
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // serial pins
    input wire select,
    input wire serial_clk,
    input wire serial_in,
    input wire serial_out,
    input wire serial_out_oe,
    // status
    input wire standby,
    input wire busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // length of the current busy period, cleared whenever busy is low
    logic [31:0] busy_cnt_reg;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
    AST_SEL_ACTIVE: assert property (select [*8] |-> !standby)
        else $error("standby high while selected");
    AST_IDLE_STANDBY: assert property ((!select && !busy) [*8] |-> standby)
        else $error("standby low while deselected and idle");
    AST_DEFER: assert property (busy [*3] |-> !standby)
        else $error("standby entered during programming");
    AST_OE_RELEASE: assert property ($fell(select) |-> ##[1:6] !serial_out_oe)
        else $error("output still driven after deselect");
    AST_START_DESEL: assert property ($rose(busy) |-> !select)
        else $error("programming began while selected");
    AST_STATUS_LOW: assert property ((busy && serial_out_oe) [*3] |-> !serial_out)
        else $error("status not low while busy");
    AST_STATUS_HIGH: assert property ($fell(busy) && select |-> ##[0:4] (serial_out && serial_out_oe))
        else $error("status not high after completion");
    AST_BUSY_MAX: assert property (busy |-> busy_cnt_reg <= T_WRITE_WHOLE_ARRAY_CYC + 8)
        else $error("busy period too long");
    AST_BUSY_MIN: assert property ($fell(busy) |->
        busy_cnt_reg + 8 >= ((T_WRITE_CYC < T_ERASE_WHOLE_ARRAY_CYC) ? T_WRITE_CYC : T_ERASE_WHOLE_ARRAY_CYC))
        else $error("programming cut short");
endmodule
bind serial_eeprom serial_eeprom_checker #(.T_WRITE_CYC(T_WRITE_CYC), .T_ERASE_WHOLE_ARRAY_CYC(T_ERASE_WHOLE_ARRAY_CYC),
    .T_WRITE_WHOLE_ARRAY_CYC(T_WRITE_WHOLE_ARRAY_CYC)) chk (.clk(clk), .rst_n(rst_n), .ce(ce), .select(select),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .standby(standby), .busy(busy));

// ===== tb/link_master.sv
`timescale 1ns/1ps
module link_master (
    // system clock
    input wire clk,
    // serial pins
    output logic select,
    output logic serial_clk,
    output logic serial_in,
    input wire serial_out,
    input wire serial_out_oe
);
    initial begin
        select = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // one link clock is 40 system clocks; it stands low outside frames
    task automatic shift(input logic [31:0] bits, input int n, output logic [31:0] q);
        q = 32'h0;
        select <= 1'b1;
        repeat (20) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= bits[i];
            repeat (20) @(posedge clk);
            serial_clk <= 1'b1;
            repeat (20) @(posedge clk);
            serial_clk <= 1'b0;
            q = {q[30:0], serial_out_oe ? serial_out : 1'bx};
        end
    endtask
    // released data line shows the inverse of its last level
    task automatic release_sel;
        select <= 1'b0;
        serial_in <= ~serial_in;
        repeat (70) @(posedge clk);
    endtask
endmodule

// ===== tb/serial_eeprom_select_program_ctrl_test.sv
`timescale 1ns/1ps
`include "eeprom_ctrl_regs.vh"
module serial_eeprom_select_program_ctrl_test;
    localparam int TW = 300;
    localparam int TL = 600;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    wire select, serial_clk, serial_in, serial_out, serial_out_oe, standby, busy;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int t_wr, t_al;
    logic [31:0] q;
    always #2 clk = ~clk;
    serial_eeprom #(.WORD16(1), .T_WRITE_CYC(TW), .T_ERASE_WHOLE_ARRAY_CYC(TW), .T_WRITE_WHOLE_ARRAY_CYC(TL)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .select(select), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .standby(standby), .busy(busy));
    link_master master (.clk(clk), .select(select), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // whole instruction in one frame, then deselect for the minimum gap
    task automatic instr(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d, input bit wd);
        if (wd)
            master.shift({6'h0, 1'b1, op, a, d}, 26, q);
        else
            master.shift({22'h0, 1'b1, op, a}, 10, q);
        master.release_sel();
    endtask
    // read: dummy zero then the word, most significant bit first
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        master.shift({6'h0, 1'b1, `OP_READ, a, 16'h0}, 26, q);
        master.release_sel();
        chk("read word", {16'h0, exp}, {15'h0, q[16:0]});
    endtask
    // bounded wait for the end of a self-timed cycle
    task automatic prog(output int dur);
        dur = 0;
        chk("busy after deselect", 1, busy);
        while (busy === 1'b1 && dur < 2000) begin
            @(posedge clk);
            dur++;
        end
        chk("busy ends", 0, busy);
    endtask
    task automatic t_lock;
        instr(`OP_WRITE, 7'h05, 16'hA5C3, 1);
        chk("write while locked", 0, busy);
        instr(`OP_EXT, {`EXT_UNLOCK, 5'h0}, 16'h0, 0);
    endtask
    task automatic t_write;
        instr(`OP_EXT, {`EXT_WRITE_WHOLE_ARRAY, 5'h0}, 16'h3C5A, 1);
        prog(t_al);
        instr(`OP_WRITE, 7'h05, 16'hC3A5, 1);
        master.shift(32'h0, 0, q);
        chk("status busy", 32'h2, {serial_out_oe, serial_out});
        master.release_sel();
        chk("standby deferred", 0, standby);
        master.shift(32'h0, 0, q);
        prog(t_wr);
        repeat (8) @(posedge clk);
        chk("status ready", 32'h3, {serial_out_oe, serial_out});
        chk("selected not standby", 0, standby);
        master.release_sel();
        chk("standby when idle", 1, standby);
        chk("output released", 0, serial_out_oe);
        chk("whole-array longer", 1, t_al > t_wr);
        rd(7'h05, 16'hC3A5);
        rd(7'h7F, 16'h3C5A);
        rd(7'h00, 16'h3C5A);
    endtask
    task automatic t_erase_whole_array;
        instr(`OP_ERASE, 7'h05, 16'h0, 0);
        prog(t_wr);
        rd(7'h05, 16'hFFFF);
        rd(7'h7F, 16'h3C5A);
        instr(`OP_EXT, {`EXT_ERASE_WHOLE_ARRAY, 5'h0}, 16'h0, 0);
        // enable held low past the cycle's natural end; busy must stay frozen
        ce <= 1'b0;
        repeat (250) @(posedge clk);
        chk("busy frozen by enable", 1, busy);
        ce <= 1'b1;
        prog(t_wr);
        repeat (8) @(posedge clk);
        chk("standby after erase", 1, standby);
        rd(7'h7F, 16'hFFFF);
    endtask
    task automatic t_abort;
        master.shift({26'h0, 1'b1, `OP_WRITE, 3'h5}, 6, q);
        master.release_sel();
        chk("partial write ignored", 0, busy);
        master.shift({3'h0, 1'b1, `OP_READ, 7'h05, 16'h0}, 29, q);
        master.release_sel();
        chk("read after idle zeros", {15'h0, 17'h0FFFF}, {15'h0, q[16:0]});
        instr(`OP_EXT, {`EXT_LOCK, 5'h0}, 16'h0, 0);
        instr(`OP_WRITE, 7'h05, 16'h1234, 1);
        chk("write after lock", 0, busy);
        rd(7'h05, 16'hFFFF);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("standby after reset", 1, standby);
        t_lock();
        t_write();
        t_erase_whole_array();
        t_abort();
        end_sim();
    end
    // cut a hang short well past the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            $display("ERROR timeout expected done seen running");
            end_sim();
        end
    end
endmodule
